// ==== src/pager_rx_control_config.sv ====
// receiver control configuration, sequencing and frame assignment table
// Function
// - battery_check_flag set: sample low battery input just before leaving state; resets zero.
// - drive each state's programmed line_value on receiver control lines; resets zero.
// - final warm-up dwell in 625 us units, codes 01..7F, reset one unit.
// - sync state waits its dwell after warm-up before sliced symbols count valid.
// - sync packet id 0x16, flag byte2 bit3, line byte1, dwell byte0[6:0].
// - receiver-on packets select state by low nibble 7, 8 or 9; byte0 zero.
// - shut-down packets id upper 0001101, bit0 picks step one or two.
// - disabled shut-down step skips itself and later steps; enables reset zero.
// - shut-down dwell byte0[5:0] in 625 us units, codes 01..3F, reset one.
// - accept frame packets ids 32..39, low id bits index, low bytes sixteen bits.
// - index 0 covers frames 127..112 downward; index 7 covers 15..0.
// - frames with assigned bit set are decoded, others ignored; bits reset zero.
// - ignore configuration packets ids 16..27 while decoder run is set.
`timescale 1ns/10ps
`default_nettype none
`include "rx_ctrl_defines.svh"
module pager_rx_control_config
    import rx_ctrl_pkg::*;
#(
    parameter int UNIT_CYCLES = `DWELL_UNIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pkt_valid,
    input  wire logic [31:0] pkt_data,
    input  wire logic        decoder_run,
    input  wire logic        cycle_start,
    input  wire logic        warmup_done,
    input  wire logic [6:0]  frame_query,
    input  wire logic        low_battery_input,
    input  wire logic        sliced_symbol_hi,
    input  wire logic        sliced_symbol_lo,
    output logic [7:0]       receiver_ctrl_lines,
    output logic             symbols_valid,
    output logic [1:0]       sliced_symbols,
    output logic             low_battery_seen,
    output logic             batt_sample_strobe,
    output logic             frame_assigned,
    output logic             rx_busy,
    output logic [2:0]       rx_state
);
    rx_state_cfg_s cfg_reg [7];
    rx_state_cfg_s cfg_next [7];
    logic [15:0] frame_bits_reg [8];
    logic [15:0] frame_bits_next [8];
    rx_state_e   state_reg;
    rx_state_e   state_next;
    logic        timer_start;
    logic        timer_expired;
    logic [6:0]  timer_units;
    logic        batt_sync;
    logic [1:0]  sym_sync;
    logic        batt_next;
    logic        strobe_next;
    logic        valid_next;
    packet_s     pkt;
    logic [7:0]  lines_next;
    logic [1:0]  symbols_next;
    logic        assigned_next;
    logic [2:0]  query_group;

    assign pkt = packet_s'(pkt_data);

    sync2 #(.W(3)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({low_battery_input, sliced_symbol_hi, sliced_symbol_lo}),
        .q     ({batt_sync, sym_sync})
    );

    dwell_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (timer_start),
        .units   (timer_units),
        .expired (timer_expired)
    );

    // map state to its slot in the configuration table
    function automatic int slot_of(input rx_state_e s);
        unique case (s)
            ST_OFF:         slot_of = 0;
            ST_SYNC:        slot_of = 1;
            ST_ON_SYNC1600: slot_of = 2;
            ST_ON_DATA3200: slot_of = 3;
            ST_ON_DATA1600: slot_of = 4;
            ST_SHUT1:       slot_of = 5;
            ST_SHUT2:       slot_of = 6;
        endcase
    endfunction

    // frame assignment packets: ids 32..39 with byte 2 clear
    function automatic logic is_frame_pkt(input packet_s p);
        is_frame_pkt = (p.id[7:3] == `ID_FRAME_HI) && (p.b2 == 8'h00);
    endfunction

    // receiver control range; off and warm-up ids share it but are not stored here
    function automatic logic is_cfg_pkt(input packet_s p);
        is_cfg_pkt = (p.id >= `ID_CFG_LO) && (p.id <= `ID_CFG_HI);
    endfunction

    // shut-down setting number picks step one or step two
    function automatic int shut_slot(input packet_s p);
        shut_slot = 5 + int'(p.id[0]);
    endfunction

    // group 0 holds frames 127..112, so the group runs opposite to the frame's top bits
    function automatic logic [2:0] group_of(input logic [6:0] frame);
        group_of = 3'h7 - frame[6:4];
    endfunction

    // configuration packet decode
    always_comb begin
        logic reserved_ok;
        reserved_ok = 1'b0;
        for (int i = 0; i < 7; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        for (int i = 0; i < 8; i++) begin
            frame_bits_next[i] = frame_bits_reg[i];
        end
        if (pkt_valid) begin
            if (is_frame_pkt(pkt)) begin
                frame_bits_next[pkt.id[2:0]] = {pkt.b1, pkt.b0};
            end else if (!decoder_run && is_cfg_pkt(pkt)) begin
                reserved_ok = (pkt.b2 & 8'h77) == 8'h00;
                if (pkt.id == `ID_SYNC3200 && reserved_ok && !pkt.b2[`BIT_STEP_EN] && !pkt.b0[7]) begin
                    cfg_next[1].battery_check_flag = pkt.b2[`BIT_BATT_CHK];
                    cfg_next[1].line_value         = pkt.b1;
                    cfg_next[1].dwell_period       = pkt.b0[6:0];
                end else if (pkt.id[7:1] == `ID_SHUT_HI && reserved_ok && pkt.b0[7:6] == 2'b00) begin
                    cfg_next[shut_slot(pkt)].step_enable        = pkt.b2[`BIT_STEP_EN];
                    cfg_next[shut_slot(pkt)].battery_check_flag = pkt.b2[`BIT_BATT_CHK];
                    cfg_next[shut_slot(pkt)].line_value         = pkt.b1;
                    cfg_next[shut_slot(pkt)].dwell_period       = {1'b0, pkt.b0[5:0]};
                end else if (reserved_ok && !pkt.b2[`BIT_STEP_EN] && pkt.b0 == 8'h00) begin
                    if (pkt.id[3:0] == `SET_SYNC1600) begin
                        cfg_next[2].battery_check_flag = pkt.b2[`BIT_BATT_CHK];
                        cfg_next[2].line_value         = pkt.b1;
                    end else if (pkt.id[3:0] == `SET_DATA3200) begin
                        cfg_next[3].battery_check_flag = pkt.b2[`BIT_BATT_CHK];
                        cfg_next[3].line_value         = pkt.b1;
                    end else if (pkt.id[3:0] == `SET_DATA1600) begin
                        cfg_next[4].battery_check_flag = pkt.b2[`BIT_BATT_CHK];
                        cfg_next[4].line_value         = pkt.b1;
                    end
                end
                // other ids in range belong to off and warm-up, left unchanged
            end
        end
    end

    // receiver sequencing
    always_comb begin
        state_next  = state_reg;
        timer_start = 1'b0;
        timer_units = cfg_reg[1].dwell_period;
        valid_next  = symbols_valid;
        unique case (state_reg)
            ST_OFF: begin
                valid_next = 1'b0;
                if (decoder_run && cycle_start && warmup_done) begin
                    state_next  = ST_SYNC;
                    timer_start = 1'b1;
                    timer_units = cfg_reg[1].dwell_period;
                end
            end
            ST_SYNC: begin
                if (timer_expired) begin
                    valid_next = 1'b1;
                    state_next = ST_ON_SYNC1600;
                end
            end
            ST_ON_SYNC1600: begin
                if (cycle_start) begin
                    state_next = ST_ON_DATA3200;
                end
            end
            ST_ON_DATA3200: begin
                if (cycle_start) begin
                    state_next = ST_ON_DATA1600;
                end
            end
            ST_ON_DATA1600: begin
                if (cycle_start || !decoder_run) begin
                    valid_next = 1'b0;
                    if (cfg_reg[5].step_enable) begin
                        state_next  = ST_SHUT1;
                        timer_start = 1'b1;
                        timer_units = cfg_reg[5].dwell_period;
                    end else begin
                        state_next = ST_OFF;
                    end
                end
            end
            ST_SHUT1: begin
                if (timer_expired) begin
                    if (cfg_reg[6].step_enable) begin
                        state_next  = ST_SHUT2;
                        timer_start = 1'b1;
                        timer_units = cfg_reg[6].dwell_period;
                    end else begin
                        state_next = ST_OFF;
                    end
                end
            end
            ST_SHUT2: begin
                if (timer_expired) begin
                    state_next = ST_OFF;
                end
            end
        endcase
    end

    // battery is sampled on the edge that leaves a state whose check flag is set
    always_comb begin
        batt_next   = low_battery_seen;
        strobe_next = 1'b0;
        if (state_next != state_reg && cfg_reg[slot_of(state_reg)].battery_check_flag) begin
            batt_next   = batt_sync;
            strobe_next = 1'b1;
        end
    end

    // outputs follow the state being entered, so lines and state change on one edge
    always_comb begin
        lines_next    = cfg_reg[slot_of(state_next)].line_value;
        symbols_next  = valid_next ? sym_sync : 2'b00;
        query_group   = group_of(frame_query);
        assigned_next = frame_bits_reg[query_group][frame_query[3:0]];
    end

    // one register slot per receiver state
    for (genvar s = 0; s < 7; s++) begin : g_cfg
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cfg_reg[s] <= '{1'b0, 1'b0, `LINE_RESET, `DWELL_RESET};
            end else begin
                cfg_reg[s] <= cfg_next[s];
            end
        end
    end

    // one sixteen-frame group per frame assignment packet
    for (genvar g = 0; g < 8; g++) begin : g_frame
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                frame_bits_reg[g] <= 16'h0000;
            end else begin
                frame_bits_reg[g] <= frame_bits_next[g];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg           <= ST_OFF;
            receiver_ctrl_lines <= `LINE_RESET;
        end else begin
            state_reg           <= state_next;
            receiver_ctrl_lines <= lines_next;
        end
    end

    // symbols pass only once the sync dwell has run out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            symbols_valid  <= 1'b0;
            sliced_symbols <= 2'b00;
        end else begin
            symbols_valid  <= valid_next;
            sliced_symbols <= symbols_next;
        end
    end

    // last sampled battery level and its one-cycle sample strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_battery_seen   <= 1'b0;
            batt_sample_strobe <= 1'b0;
        end else begin
            low_battery_seen   <= batt_next;
            batt_sample_strobe <= strobe_next;
        end
    end

    // frame lookup answers one cycle after the query
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_assigned <= 1'b0;
        end else begin
            frame_assigned <= assigned_next;
        end
    end

    assign rx_busy  = (state_reg != ST_OFF);
    assign rx_state = state_reg;
endmodule
`default_nettype wire

// ==== src/rx_ctrl_defines.svh ====
// constants for the receiver control configuration block
`ifndef RX_CTRL_DEFINES_SVH
`define RX_CTRL_DEFINES_SVH
`define ID_SYNC3200        8'h16
`define ID_ON_HI           4'h1
`define SET_SYNC1600       4'h7
`define SET_DATA3200       4'h8
`define SET_DATA1600       4'h9
`define ID_SHUT_HI         7'h0D
`define ID_FRAME_HI        5'h04
`define ID_CFG_LO          8'h10
`define ID_CFG_HI          8'h1B
`define BIT_STEP_EN        7
`define BIT_BATT_CHK       3
`define LINE_RESET         8'h00
`define DWELL_RESET        7'h01
`define DWELL_UNIT_NS      625000
`define CLK_PERIOD_NS      50
`define DWELL_UNIT_CYCLES  (`DWELL_UNIT_NS / `CLK_PERIOD_NS)
`endif

// ==== src/rx_ctrl_pkg.sv ====
// types for the receiver control configuration block
package rx_ctrl_pkg;
    typedef struct packed {
        logic       battery_check_flag;
        logic       step_enable;
        logic [7:0] line_value;
        logic [6:0] dwell_period;
    } rx_state_cfg_s;

    typedef struct packed {
        logic [7:0] id;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } packet_s;

    typedef enum logic [2:0] {
        ST_OFF, ST_SYNC, ST_ON_SYNC1600, ST_ON_DATA3200, ST_ON_DATA1600, ST_SHUT1, ST_SHUT2
    } rx_state_e;
endpackage

// ==== src/dwell_timer.sv ====
// dwell timer counting 625 us units
`timescale 1ns/10ps
`default_nettype none
`include "rx_ctrl_defines.svh"
module dwell_timer
    import rx_ctrl_pkg::*;
#(
    parameter int UNIT_CYCLES = `DWELL_UNIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [6:0] units,
    output logic            expired
);
    logic [13:0] tick_reg;
    logic [13:0] tick_next;
    logic [6:0]  unit_reg;
    logic [6:0]  unit_next;
    logic        run_reg;
    logic        run_next;
    logic        exp_next;

    always_comb begin
        tick_next = tick_reg;
        unit_next = unit_reg;
        run_next  = run_reg;
        exp_next  = 1'b0;
        if (start) begin
            tick_next = 14'h0000;
            unit_next = (units == 7'h00) ? 7'h01 : units;
            run_next  = 1'b1;
        end else if (run_reg) begin
            if (tick_reg == 14'(UNIT_CYCLES - 1)) begin
                tick_next = 14'h0000;
                unit_next = unit_reg - 7'h01;
                if (unit_reg == 7'h01) begin
                    run_next = 1'b0;
                    exp_next = 1'b1;
                end
            end else begin
                tick_next = tick_reg + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= 14'h0000;
            unit_reg <= 7'h00;
            run_reg  <= 1'b0;
            expired  <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            unit_reg <= unit_next;
            run_reg  <= run_next;
            expired  <= exp_next;
        end
    end
endmodule
`default_nettype wire

// ==== src/sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rx_host_model.sv ====
// host side packet source for the receiver control block
`timescale 1ns/10ps
`default_nettype none
module rx_host_model
    import rx_ctrl_pkg::*;
(
    input  wire logic clk,
    output logic      pkt_valid,
    output packet_s   pkt_data
);
    initial begin
        pkt_valid = 1'b0;
        pkt_data  = '0;
    end
    // one whole packet per call, launched after a falling edge
    task automatic send(input packet_s p);
        @(negedge clk);
        pkt_valid = 1'b1;
        pkt_data  = p;
        @(negedge clk);
        pkt_valid = 1'b0;
        // released data shows the inverse, never the stale packet
        pkt_data  = ~p;
    endtask
endmodule
`default_nettype wire

// ==== tb/rx_ctrl_properties.sv ====
// port assertions for the receiver control block
`timescale 1ns/10ps
`default_nettype none
module rx_ctrl_properties #(
    parameter int UNIT_CYCLES = 12500
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       decoder_run,
    input wire logic       cycle_start,
    input wire logic       warmup_done,
    input wire logic       symbols_valid,
    input wire logic [1:0] sliced_symbols,
    input wire logic       batt_sample_strobe,
    input wire logic       rx_busy,
    input wire logic [2:0] rx_state
);
    logic [31:0] sync_reg;
    logic [31:0] sync_next;
    always_comb begin
        sync_next = (rx_state == 3'h1) ? sync_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= 32'h0;
        end else begin
            sync_reg <= sync_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    busy_follows_a: assert property (rx_busy == (rx_state != 3'h0)) else $error("busy flag wrong");
    sym_gate_a: assert property (!symbols_valid |-> sliced_symbols == 2'h0) else $error("symbols leak");
    sync_mute_a: assert property (rx_state == 3'h1 |-> !symbols_valid) else $error("valid in sync");
    strobe_exit_a: assert property (batt_sample_strobe |-> rx_state != $past(rx_state))
        else $error("strobe without exit");
    run_start_a: assert property (rx_state == 3'h0 && decoder_run && cycle_start && warmup_done
        |=> rx_state == 3'h1) else $error("no sync entry");
    idle_hold_a: assert property (rx_state == 3'h0 && !decoder_run |=> rx_state == 3'h0)
        else $error("left off idle");
    sync_exit_a: assert property (rx_state == 3'h1 ##1 rx_state != 3'h1 |-> rx_state == 3'h2)
        else $error("bad sync exit");
    on_order_a: assert property (rx_state == 3'h2 ##1 rx_state != 3'h2 |-> rx_state == 3'h3)
        else $error("bad on order");
    shut_skip_a: assert property (rx_state == 3'h5 ##1 rx_state != 3'h5 |-> rx_state inside {3'h0, 3'h6})
        else $error("bad shut exit");
    sync_bound_a: assert property (sync_reg <= 127 * UNIT_CYCLES + 1) else $error("sync dwell long");
    cover property (rx_state == 3'h1);
    cover property (rx_state == 3'h5);
    cover property (batt_sample_strobe);
endmodule
bind pager_rx_control_config rx_ctrl_properties #(.UNIT_CYCLES(UNIT_CYCLES)) chk (.clk(clk),
    .rst_n(rst_n), .decoder_run(decoder_run), .cycle_start(cycle_start), .warmup_done(warmup_done),
    .symbols_valid(symbols_valid), .sliced_symbols(sliced_symbols),
    .batt_sample_strobe(batt_sample_strobe), .rx_busy(rx_busy), .rx_state(rx_state));
`default_nettype wire

// ==== tb/pager_rx_control_config_bench.sv ====
// self-checking bench for the receiver control block
`timescale 1ns/10ps
`default_nettype none
module pager_rx_control_config_bench;
    import rx_ctrl_pkg::*;
    logic       clk, rst_n, pkt_valid, decoder_run, cycle_start, warmup_done;
    logic       low_battery_input, sliced_symbol_hi, sliced_symbol_lo;
    logic       symbols_valid, low_battery_seen, batt_sample_strobe, frame_assigned, rx_busy;
    logic [6:0] frame_query;
    logic [7:0] receiver_ctrl_lines;
    logic [1:0] sliced_symbols;
    logic [2:0] rx_state;
    packet_s    pkt_data;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         strobes = 0;
    int         cyc = 0;
    rx_host_model host (.clk(clk), .pkt_valid(pkt_valid), .pkt_data(pkt_data));
    pager_rx_control_config #(.UNIT_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .decoder_run(decoder_run), .cycle_start(cycle_start),
        .warmup_done(warmup_done), .frame_query(frame_query), .low_battery_input(low_battery_input),
        .sliced_symbol_hi(sliced_symbol_hi), .sliced_symbol_lo(sliced_symbol_lo),
        .receiver_ctrl_lines(receiver_ctrl_lines), .symbols_valid(symbols_valid),
        .sliced_symbols(sliced_symbols), .low_battery_seen(low_battery_seen),
        .batt_sample_strobe(batt_sample_strobe), .frame_assigned(frame_assigned),
        .rx_busy(rx_busy), .rx_state(rx_state));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        if (batt_sample_strobe === 1'b1) strobes++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask
    task automatic query(input logic [6:0] f, input logic exp);
        frame_query = f;
        @(negedge clk);
        chk(frame_assigned, exp, "frame bit");
    endtask
    task automatic pulse;
        cycle_start = 1'b1;
        @(negedge clk);
        cycle_start = 1'b0;
    endtask
    task automatic wait_state(input logic [2:0] s, output int n);
        n = 0;
        while (rx_state !== s && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(rx_state, s, "state");
    endtask
    task automatic t_reset;
        chk(receiver_ctrl_lines, 8'h00, "lines at reset");
        chk(rx_state, 3'h0, "state at reset");
        for (int f = 0; f < 128; f++) query(f[6:0], 1'b0);
    endtask
    task automatic t_frames;
        // group i sets only bit i, so each frame's expectation is unique
        for (int i = 0; i < 8; i++) host.send({8'h20 + 8'(i), 8'h00, 16'h1 << i});
        @(negedge clk);
        for (int f = 0; f < 128; f++) query(f[6:0], f[3:0] == 4'(7 - f[6:4]));
    endtask
    task automatic t_bad;
        host.send({8'h20, 8'h01, 16'hFFFF});
        host.send({8'h28, 8'h00, 16'hFFFF});
        @(negedge clk);
        query(7'h7F, 1'b0);
        query(7'h70, 1'b1);
    endtask
    task automatic t_collapse;
        // one address on frame 3 collapsing every sixteen frames
        for (int g = 0; g < 8; g++) host.send({8'h20 + 8'(g), 8'h00, 16'h0008});
        @(negedge clk);
        for (int f = 0; f < 128; f++) query(f[6:0], f[3:0] == 4'h3);
    endtask
    task automatic t_seq;
        int n;
        host.send({8'h16, 8'h08, 8'hA5, 8'h02});
        host.send({8'h17, 8'h00, 8'h11, 8'h00});
        host.send({8'h18, 8'h00, 8'h22, 8'h00});
        host.send({8'h19, 8'h00, 8'h33, 8'h00});
        host.send({8'h1A, 8'h80, 8'h44, 8'h01});
        host.send({8'h1B, 8'h00, 8'h66, 8'h01});
        decoder_run = 1'b1;
        pulse();
        wait_state(3'h1, n);
        chk(receiver_ctrl_lines, 8'hA5, "sync line");
        chk(symbols_valid, 8'h00, "muted in sync");
        chk(rx_busy, 8'h01, "busy in sync");
        wait_state(3'h2, n);
        chk(n >= 8 && n <= 10, 8'h01, "sync dwell");
        @(negedge clk);
        chk(strobes[7:0], 8'h01, "battery strobe");
        chk(low_battery_seen, 8'h01, "battery level");
        chk(sliced_symbols, 8'h02, "symbols");
        chk(receiver_ctrl_lines, 8'h11, "on line");
        chk(symbols_valid, 8'h01, "symbols valid");
        host.send({8'h16, 8'h00, 8'h5A, 8'h01});
        pulse();
        wait_state(3'h3, n);
        chk(receiver_ctrl_lines, 8'h22, "data line");
        pulse();
        wait_state(3'h4, n);
        chk(receiver_ctrl_lines, 8'h33, "slow line");
        pulse();
        wait_state(3'h5, n);
        chk(receiver_ctrl_lines, 8'h44, "shut line");
        wait_state(3'h0, n);
        chk(n >= 4 && n <= 6, 8'h01, "shut dwell");
        chk(rx_busy, 8'h00, "idle after shut");
        chk(symbols_valid, 8'h00, "muted when off");
        pulse();
        wait_state(3'h1, n);
        chk(receiver_ctrl_lines, 8'hA5, "kept sync line");
    endtask
    initial begin
        rst_n = 1'b0;
        decoder_run = 1'b0;
        cycle_start = 1'b0;
        warmup_done = 1'b1;
        frame_query = 7'h00;
        low_battery_input = 1'b1;
        sliced_symbol_hi = 1'b1;
        sliced_symbol_lo = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        $display("reset test done");
        t_frames();
        $display("frame test done");
        t_bad();
        $display("refusal test done");
        t_collapse();
        $display("collapse test done");
        t_seq();
        $display("sequence test done");
        results();
    end
endmodule
`default_nettype wire
